/* logic/sdl_pkg.sv */
/*
 * constants for the serial converter input latch: widths, reset values,
 * code scaling figures.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package sdl_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int SHIFT_W   = 16;
	localparam int LATCH_W   = 12;
	localparam int CODE_W    = 10;
	localparam int SUB_LSB_W = 2;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [SHIFT_W-1:0] SHIFT_RST = 16'h0000;
	localparam logic [LATCH_W-1:0] LATCH_RST = 12'h000;

	// ---------------------------------------------------------------
	// code scale: output = 2 * reference * code / full scale
	// ---------------------------------------------------------------
	localparam int CODE_FULL_SCALE = 1024;
	localparam logic [CODE_W-1:0] CODE_MID = 10'h200;

	// ---------------------------------------------------------------
	// state of the select front end
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SDL_IDLE  = 2'b00,
		SDL_FRAME = 2'b01
	} sdl_state_type;

endpackage

`default_nettype wire

/* logic/sdl_sync.sv */
/*
 * two flip-flop synchroniser for the three link pins.
 * assumes a free-running local clock well above the link clock rate.
 */
`timescale 1ns/10ps
`default_nettype none

module sdl_sync
	import sdl_pkg::*;
#(
	parameter int W = 3
)
(
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_b,
	// asynchronous inputs and synchronised copies, inverted where rst_val is set
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] rst_val,
	output var  logic [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					meta_reg[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_reg[i] <= async_in[i] ^ rst_val[i];
					sync_out[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* logic/sdl_latch.sv */
/*
 * serial converter input latch: 16-bit shift register loaded from the
 * serial link while select is low, 12-bit converter latch loaded on
 * the rising edge of select, chain output updated on falling link clock.
 * assumes link pins are asynchronous and the local clock samples them
 * at least four times per link clock period; rst_b models power-up.
 */
// Summary of operation
// - power-up clears the converter latch to zero
// - code is straight binary; mid code 512 gives reference voltage
// - select low shifts data into 16-bit register, MSB first
// - data sampled and register advanced on each rising link clock while select is low
// - select rising edge copies low twelve shift register bits into converter latch
// - select high ignores link clock; no data enters register
// - data in reappears at chain out after sixteen clocks plus width
// - chain output changes only on falling link clock with select low
// - select high keeps chain output driven at last bit
`timescale 1ns/10ps
`default_nettype none

module sdl_latch
	import sdl_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_b,
	// serial link pins
	input  wire logic              link_clk,
	input  wire logic              link_din,
	input  wire logic              link_sel_b,
	output var  logic              link_dout,
	// converter side
	output var  logic [CODE_W-1:0] dac_code,
	output var  logic              dac_update
);

	// ---------------------------------------------------------------
	// pin synchronisation
	// ---------------------------------------------------------------
	logic [2:0] pins_sync;
	logic       sclk_s;
	logic       din_s;
	logic       sel_b_s;

	// select resets inverted so an idle high pin starts high
	sdl_sync #(.W(3)) u_sync
	(
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in ({link_sel_b, link_clk, link_din}),
		.rst_val  (3'h4),
		.sync_out (pins_sync)
	);

	assign din_s   = pins_sync[0];
	assign sclk_s  = pins_sync[1];
	assign sel_b_s = ~pins_sync[2];

	// ---------------------------------------------------------------
	// edge detection
	// ---------------------------------------------------------------
	logic sclk_d_reg;
	logic sel_b_d_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_rise;
	logic sel_active;

	assign sclk_rise  = sclk_s & ~sclk_d_reg;
	assign sclk_fall  = ~sclk_s & sclk_d_reg;
	assign sel_rise   = sel_b_s & ~sel_b_d_reg;
	assign sel_active = ~sel_b_s;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclk_d_reg  <= 1'b0;
			sel_b_d_reg <= 1'b1;
		end
		else
		begin
			sclk_d_reg  <= sclk_s;
			sel_b_d_reg <= sel_b_s;
		end
	end

	// ---------------------------------------------------------------
	// frame state
	// ---------------------------------------------------------------
	sdl_state_type state_reg;
	sdl_state_type state_next;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			SDL_IDLE:
				if (sel_active)
					state_next = SDL_FRAME;
			SDL_FRAME:
				if (sel_rise)
					state_next = SDL_IDLE;
			default:
				state_next = SDL_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			state_reg <= SDL_IDLE;
		else
			state_reg <= state_next;
	end

	// only a select rise that closes an opened frame loads the latch
	logic load_en;

	assign load_en = sel_rise & (state_reg == SDL_FRAME);

	// ---------------------------------------------------------------
	// shift register
	// ---------------------------------------------------------------
	logic [SHIFT_W-1:0] shift_reg;
	logic [SHIFT_W-1:0] shift_next;
	logic               shift_en;

	assign shift_en   = sel_active & sclk_rise;
	assign shift_next = {shift_reg[SHIFT_W-2:0], din_s};

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			shift_reg <= SHIFT_RST;
		else if (shift_en)
			shift_reg <= shift_next;
	end

	// ---------------------------------------------------------------
	// converter latch
	// ---------------------------------------------------------------
	logic [LATCH_W-1:0] latch_reg;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			latch_reg <= LATCH_RST;
		else if (load_en)
			latch_reg <= shift_reg[LATCH_W-1:0];
	end

	// straight binary code, sub-LSB pair dropped
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dac_code   <= '0;
			dac_update <= 1'b0;
		end
		else
		begin
			dac_code   <= load_en ? shift_reg[LATCH_W-1:SUB_LSB_W]
			                       : latch_reg[LATCH_W-1:SUB_LSB_W];
			dac_update <= load_en;
		end
	end

	// ---------------------------------------------------------------
	// chain output
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			link_dout <= 1'b0;
		else if (sel_active && sclk_fall)
			link_dout <= shift_reg[SHIFT_W-1];
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_power_up_zero;
		@(posedge clock) $rose(rst_b) |-> (dac_code == '0);
	endproperty
	a_power_up_zero: assert property (p_power_up_zero)
		else $error("converter code not zero after reset");

	property p_msb_first;
		@(posedge clock) disable iff (!rst_b)
		shift_en |=> (shift_reg[0] == $past(din_s))
			&& (shift_reg[SHIFT_W-1:1] == $past(shift_reg[SHIFT_W-2:0]));
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("shift register did not move toward msb");

	property p_shift_on_rise;
		@(posedge clock) disable iff (!rst_b)
		(sel_active && sclk_rise) |=> (shift_reg[0] == $past(din_s));
	endproperty
	a_shift_on_rise: assert property (p_shift_on_rise)
		else $error("rising link clock did not shift");

	property p_latch_on_sel_rise;
		@(posedge clock) disable iff (!rst_b)
		sel_rise |=> (latch_reg == $past(shift_reg[LATCH_W-1:0]));
	endproperty
	a_latch_on_sel_rise: assert property (p_latch_on_sel_rise)
		else $error("latch not loaded at select rise");

	property p_ignore_when_idle;
		@(posedge clock) disable iff (!rst_b)
		sel_b_s |=> $stable(shift_reg);
	endproperty
	a_ignore_when_idle: assert property (p_ignore_when_idle)
		else $error("shift register moved with select high");

	property p_dout_delay;
		@(posedge clock) disable iff (!rst_b)
		(sel_active && sclk_fall) |=> (link_dout == $past(shift_reg[SHIFT_W-1]));
	endproperty
	a_dout_delay: assert property (p_dout_delay)
		else $error("chain output not the oldest bit");

	property p_dout_on_fall;
		@(posedge clock) disable iff (!rst_b)
		!(sel_active && sclk_fall) |=> $stable(link_dout);
	endproperty
	a_dout_on_fall: assert property (p_dout_on_fall)
		else $error("chain output moved off a falling edge");

	property p_dout_hold;
		@(posedge clock) disable iff (!rst_b)
		sel_b_s [*2] |-> $stable(link_dout);
	endproperty
	a_dout_hold: assert property (p_dout_hold)
		else $error("chain output changed with select high");

	property p_code_top_ten;
		@(posedge clock) disable iff (!rst_b)
		sel_rise |=> ##1 (dac_code == latch_reg[LATCH_W-1:SUB_LSB_W]);
	endproperty
	a_code_top_ten: assert property (p_code_top_ten)
		else $error("code not top ten latch bits");

	c_frame_load: cover property (@(posedge clock) disable iff (!rst_b) sel_rise);
	c_mid_code: cover property (@(posedge clock) disable iff (!rst_b)
		dac_update && dac_code == CODE_MID);
	c_chain_out: cover property (@(posedge clock) disable iff (!rst_b) $rose(link_dout));

endmodule

`default_nettype wire

/* dv/sdl_host.sv */
/*
 * host model of the serial link: drives link clock, data and select.
 * assumes a device that samples the link pins with a faster local clock.
 */
`timescale 1ns/10ps
`default_nettype none

module sdl_host
(
	// link pins
	output var  logic link_clk,
	output var  logic link_din,
	output var  logic link_sel_b,
	input  wire logic link_dout
);
	localparam time HALF = 32;
	logic           seen [1:16];

	initial
	begin
		link_clk   = 1'b0;
		link_din   = 1'b0;
		link_sel_b = 1'b1;
	end

	// n bits msb first, 64 ns link period; chain output kept as each rise
	// is launched, as a next device in the chain would take it; select left low
	task automatic frame(input logic [15:0] word, input int n);
		int i;
		link_sel_b = 1'b0;
		for (i = n - 1; i >= 0; i--)
		begin
			link_din = word[i];
			#HALF seen[n - i] = link_dout;
			link_clk = 1'b1;
			#HALF link_clk = 1'b0;
		end
	endtask

	task automatic close();
		#HALF link_sel_b = 1'b1;
		link_din = ~link_din;
	endtask

	// clocks with select high, only used to prove they are ignored
	task automatic idle_clocks(input int n);
		repeat (n)
		begin
			link_din = ~link_din;
			#HALF link_clk = 1'b1;
			#HALF link_clk = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

/* dv/tb_top.sv */
/*
 * self-checking bench for the serial converter input latch.
 * assumes the host model in sdl_host and the package sdl_pkg.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import sdl_pkg::*;
;
	logic              clock;
	logic              rst_b;
	logic              link_clk;
	logic              link_din;
	logic              link_sel_b;
	logic              link_dout;
	logic [CODE_W-1:0] dac_code;
	logic              dac_update;
	int                mismatches;
	int                checks_done;
	logic [15:0]       word_a;

	sdl_latch DUT (.clock(clock), .rst_b(rst_b), .link_clk(link_clk), .link_din(link_din),
		.link_sel_b(link_sel_b), .link_dout(link_dout), .dac_code(dac_code),
		.dac_update(dac_update));
	sdl_host host (.link_clk(link_clk), .link_din(link_din), .link_sel_b(link_sel_b),
		.link_dout(link_dout));

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// waits for the load pulse, then checks code and one-cycle width
	task automatic expect_load(input logic [15:0] word);
		int k;
		k = 0;
		while (dac_update !== 1'b1 && k < 40)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		check({15'h0, dac_update}, 16'h1, "load pulse");
		check({6'h0, dac_code}, {6'h0, word[11:2]}, "code");
		@(posedge clock);
		#1;
		check({15'h0, dac_update}, 16'h0, "pulse width");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic t_load(input logic [15:0] word, input int n, input string name);
		logic [CODE_W-1:0] old;
		old = dac_code;
		host.frame(word, n);
		#20 check({6'h0, dac_code}, {6'h0, old}, "early load");
		host.close();
		expect_load(word);
		$display("test %s done", name);
	endtask

	task automatic t_chain();
		int i;
		word_a = 16'hc3a4;
		t_load(word_a, 16, "chain first");
		host.frame(16'h5a3c, 16);
		for (i = 1; i <= 16; i++)
			check({15'h0, host.seen[i]}, {15'h0, word_a[16 - i]}, "chain out");
		host.close();
		expect_load(16'h5a3c);
		$display("test chain done");
	endtask

	task automatic t_idle();
		host.idle_clocks(5);
		// last bit out was the msb of the second chain word, a zero
		check({15'h0, link_dout}, 16'h0, "held out");
		host.frame(16'h0, 0);
		host.close();
		expect_load(16'h5a3c);
		$display("test idle done");
	endtask

	task automatic t_reset();
		repeat (4) @(posedge clock);
		#1 check({6'h0, dac_code}, 16'h0, "reset code");
		check({15'h0, link_dout}, 16'h0, "reset out");
		check({15'h0, dac_update}, 16'h0, "reset pulse");
		$display("test reset done");
	endtask

	initial
	begin
		rst_b       = 1'b0;
		mismatches  = 0;
		checks_done = 0;
		repeat (20) @(posedge clock);
		#1 rst_b = 1'b1;
		t_reset();
		t_load(16'h0800, 12, "twelve");
		t_load(16'haffc, 16, "sixteen");
		// two bytes in one select period: 0x05 then 0x54 leave 0x554 latched
		host.frame(16'h0005, 8);
		t_load(16'h0554, 8, "bytes");
		check({6'h0, dac_code}, 16'h0155, "byte code");
		t_load(16'h0000, 12, "zero");
		t_chain();
		t_idle();
		wrap_up();
	end

	initial
	begin
		#100000;
		mismatches++;
		wrap_up();
	end
endmodule

`default_nettype wire
